// file: logic/cache_maint_cfg.svh
// cache maintenance unit: opcode fields, operand fields, geometry
// assumes one core clock; included by bare name
`ifndef CACHE_MAINT_CFG_SVH
`define CACHE_MAINT_CFG_SVH
`define SEC_WFI 4'h0
`define SEC_INV_I 4'h5
`define SEC_INV_D 4'h6
`define SEC_INV_BOTH 4'h7
`define SEC_CLEAN 4'hA
`define SEC_PREFETCH 4'hD
`define SEC_CLEAN_INV 4'hE
`define OP_WHOLE 3'h0
`define OP_MVA 3'h1
`define OP_SETWAY 3'h2
`define OP_TEST 3'h3
`define OP_BARRIER 3'h4
`define STATUS_CLEAN_BIT 30
`define RETURN_LINK_OFFSET 32'h0000_0008
`define LINE_WORDS 8
`define CACHE_WAYS 4
`define CACHE_BYTES 16384
`define WORD_LSB 2
`define SET_LSB 5
`define WAY_MSB 31
`define TEST_SPAN 4
`endif

// file: logic/cache_maint_pkg.sv
// cache maintenance unit types
// assumes the _cfg header supplies numeric constants
package cache_maint_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_DRAIN = 4'b0001,
    ST_WB = 4'b0010,
    ST_FILL = 4'b0011,
    ST_SLEEP = 4'b0100,
    ST_TEST = 4'b0101,
    ST_LINE = 4'b0110,
    ST_WHOLE = 4'b0111,
    ST_DONE = 4'b1000
  } state_t;
  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_CLEAN = 2'b01,
    ACT_INV = 2'b10,
    ACT_CLEAN_INV = 2'b11
  } act_t;
endpackage

// file: logic/cache_maint.sv
// What this block does
// - prefetch looks up, linefills on cacheable miss
// - drain empties write buffer, stalls core
// - wait drains, sleeps until interrupt or debug
// - wake completes wait, link is address plus eight
// - whole invalidate fields 7, 5, 6 selector 0
// - instruction line invalidate field 5, selectors 1,2
// - data line invalidate field 6, selectors 1,2
// - data line clean field 10, selectors 1,2
// - data line clean-invalidate field 14, selectors 1,2
// - test reads at fields 10, 14, selector 3
// - test read cleans at most one dirty line
// - bit 30 is one when nothing dirty
// - r15 destination sets flags, pc kept
// - test-invalidate invalidates data cache once clean
// - address split tag/set/word, word zero
// - set/way fields from log2 ways and sets
// - clean writes back valid dirty, clears dirty
// - line invalidate discards dirty data
//
// one module holds the whole unit; the caches' tag arrays sit outside and
// are reached through a lookup/update port answering in the same cycle.
`timescale 1ns/10ps
`include "cache_maint_cfg.svh"
module cache_maint #(
  parameter int WAYS = `CACHE_WAYS,
  parameter int SETS = `CACHE_BYTES / `CACHE_WAYS / (`LINE_WORDS * 4),
  parameter int TEST_SPAN = `TEST_SPAN
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  // coprocessor request from the core
  input wire logic op_valid,
  input wire logic op_read,
  input wire logic [3:0] secondary_register_field,
  input wire logic [2:0] op_select,
  input wire logic [3:0] dest_reg,
  input wire logic [31:0] op_data,
  input wire logic [31:0] instr_address,
  output logic core_stall,
  output logic op_done,
  output logic [31:0] read_data,
  output logic read_data_valid,
  output logic flags_update,
  output logic [3:0] flags_nzcv,
  // wait-for-interrupt wake sources, off-domain pins
  input wire logic irq_pin,
  input wire logic debug_req_pin,
  output logic low_power,
  output logic wake_irq,
  output logic [31:0] irq_return_link,
  // write buffer
  input wire logic wbuf_empty,
  // data cache tag port
  output logic [$clog2(SETS)-1:0] dc_set,
  output logic [$clog2(WAYS)-1:0] dc_way,
  output logic [31:$clog2(SETS)+`SET_LSB] dc_tag,
  output logic dc_lookup,
  input wire logic dc_hit,
  input wire logic [$clog2(WAYS)-1:0] dc_hit_way,
  input wire logic dc_valid,
  input wire logic dc_dirty,
  input wire logic dc_any_dirty,
  output logic dc_clear_dirty,
  output logic dc_invalidate_line,
  output logic dc_invalidate_all,
  // instruction cache tag port
  output logic ic_lookup,
  input wire logic ic_hit,
  input wire logic [$clog2(WAYS)-1:0] ic_hit_way,
  output logic ic_invalidate_line,
  output logic ic_invalidate_all,
  output logic [31:0] line_address,
  // memory side: line write-back and linefill
  input wire logic region_cacheable,
  output logic mem_req,
  output logic mem_write,
  input wire logic mem_done
);
  localparam int SB = $clog2(SETS);
  localparam int AB = $clog2(WAYS);
  localparam int TB = 32 - SB - `SET_LSB;

  if (WAYS < 2 || (1 << AB) != WAYS) begin : g_bad_ways
    $error("ways must be a power of two");
  end
  if (SETS < 2 || (1 << SB) != SETS ||
      SB + AB + `SET_LSB > 32) begin : g_bad_sets
    $error("sets must be a power of two that fits");
  end
  // the scan counter is eight bits wide
  if (TEST_SPAN < 1 || TEST_SPAN > SETS ||
      TEST_SPAN > 256) begin : g_bad_span
    $error("test span out of range");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    cache_maint_pkg::state_t st;
    cache_maint_pkg::act_t act;
    logic data_side;
    logic by_address;
    logic [31:0] operand;
    logic [31:0] link;
    logic is_test;
    logic test_inv;
    logic to_r15;
    logic [SB-1:0] scan_set;
    logic [AB-1:0] scan_way;
    logic [7:0] scan_count;
    logic found;
    logic [31:0] rdata;
    logic rvalid;
    logic flags;
    logic done;
    logic wake;
    logic [1:0] irq_sync;
    logic [1:0] dbg_sync;
  } state_t;

  state_t cur;
  state_t nxt;

  // field split of the operand
  logic [SB-1:0] op_set;
  logic [AB-1:0] op_way;
  logic [TB-1:0] op_tag;
  assign op_set = cur.operand[`SET_LSB +: SB];
  assign op_way = cur.operand[`WAY_MSB -: AB];
  assign op_tag = cur.operand[31 -: TB];
  // word field is not looked at: issuer holds it zero
  logic [31:0] line_base;
  assign line_base = {cur.operand[31:`SET_LSB], {`SET_LSB{1'b0}}};

  logic busy;
  assign busy = cur.st != cache_maint_pkg::ST_IDLE &&
    cur.st != cache_maint_pkg::ST_DONE;

  logic line_hit;
  assign line_hit = cur.by_address ? dc_hit : 1'b1;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt = cur;
    nxt.done = 1'b0;
    nxt.rvalid = 1'b0;
    nxt.flags = 1'b0;
    nxt.wake = 1'b0;
    nxt.irq_sync = {cur.irq_sync[0], irq_pin};
    nxt.dbg_sync = {cur.dbg_sync[0], debug_req_pin};
    unique case (cur.st)
      cache_maint_pkg::ST_IDLE, cache_maint_pkg::ST_DONE: begin
        nxt.st = cache_maint_pkg::ST_IDLE;
        if (op_valid) begin
          nxt.operand = op_data;
          nxt.link = instr_address + `RETURN_LINK_OFFSET;
          nxt.act = cache_maint_pkg::ACT_NONE;
          nxt.by_address = op_select == `OP_MVA;
          nxt.to_r15 = dest_reg == 4'hF;
          nxt.is_test = 1'b0;
          nxt.st = cache_maint_pkg::ST_DONE;
          if (op_read) begin
            // other reads are unpredictable and simply finish
            if (op_select == `OP_TEST && (secondary_register_field ==
                `SEC_CLEAN || secondary_register_field ==
                `SEC_CLEAN_INV)) begin
              nxt.is_test = 1'b1;
              nxt.test_inv = secondary_register_field == `SEC_CLEAN_INV;
              nxt.scan_count = 8'h00;
              nxt.found = 1'b0;
              nxt.st = cache_maint_pkg::ST_TEST;
            end
          end else begin
            unique case ({secondary_register_field, op_select})
              {`SEC_INV_BOTH, `OP_WHOLE}, {`SEC_INV_I, `OP_WHOLE},
              {`SEC_INV_D, `OP_WHOLE}:
                nxt.st = cache_maint_pkg::ST_WHOLE;
              {`SEC_INV_I, `OP_MVA}, {`SEC_INV_I, `OP_SETWAY}: begin
                nxt.data_side = 1'b0;
                nxt.act = cache_maint_pkg::ACT_INV;
                nxt.st = cache_maint_pkg::ST_LINE;
              end
              {`SEC_INV_D, `OP_MVA}, {`SEC_INV_D, `OP_SETWAY}: begin
                nxt.data_side = 1'b1;
                nxt.act = cache_maint_pkg::ACT_INV;
                nxt.st = cache_maint_pkg::ST_LINE;
              end
              {`SEC_CLEAN, `OP_MVA}, {`SEC_CLEAN, `OP_SETWAY}: begin
                nxt.data_side = 1'b1;
                nxt.act = cache_maint_pkg::ACT_CLEAN;
                nxt.st = cache_maint_pkg::ST_LINE;
              end
              {`SEC_CLEAN_INV, `OP_MVA},
              {`SEC_CLEAN_INV, `OP_SETWAY}: begin
                nxt.data_side = 1'b1;
                nxt.act = cache_maint_pkg::ACT_CLEAN_INV;
                nxt.st = cache_maint_pkg::ST_LINE;
              end
              {`SEC_PREFETCH, `OP_MVA}: begin
                nxt.data_side = 1'b0;
                nxt.st = cache_maint_pkg::ST_LINE;
              end
              {`SEC_CLEAN, `OP_BARRIER}:
                nxt.st = cache_maint_pkg::ST_DRAIN;
              {`SEC_WFI, `OP_BARRIER}: begin
                nxt.act = cache_maint_pkg::ACT_INV;
                nxt.st = cache_maint_pkg::ST_DRAIN;
              end
              default: nxt.st = cache_maint_pkg::ST_DONE;
            endcase
            // wait-for-interrupt reuses act as a marker
            if (secondary_register_field == `SEC_WFI)
              nxt.data_side = 1'b0;
            nxt.test_inv = secondary_register_field == `SEC_INV_BOTH ?
              1'b1 : 1'b0;
            if (secondary_register_field == `SEC_INV_D)
              nxt.data_side = 1'b1;
            if (secondary_register_field == `SEC_INV_I &&
                op_select == `OP_WHOLE)
              nxt.data_side = 1'b0;
          end
        end
      end
      cache_maint_pkg::ST_WHOLE: begin
        nxt.st = cache_maint_pkg::ST_DONE;
      end
      cache_maint_pkg::ST_LINE: begin
        // one lookup cycle, then write-back, fill or finish
        nxt.st = cache_maint_pkg::ST_DONE;
        if (cur.act == cache_maint_pkg::ACT_NONE) begin
          if (!ic_hit && region_cacheable)
            nxt.st = cache_maint_pkg::ST_FILL;
        end else if (cur.data_side && cur.act !=
            cache_maint_pkg::ACT_INV && line_hit && dc_valid &&
            dc_dirty) begin
          nxt.st = cache_maint_pkg::ST_WB;
        end
      end
      cache_maint_pkg::ST_TEST: begin
        if (dc_valid && dc_dirty) begin
          nxt.found = 1'b1;
          nxt.st = cache_maint_pkg::ST_WB;
        end else if (cur.scan_count == 8'(TEST_SPAN - 1)) begin
          nxt.st = cache_maint_pkg::ST_DONE;
        end
        nxt.scan_count = cur.scan_count + 8'h01;
        {nxt.scan_set, nxt.scan_way} = {cur.scan_set, cur.scan_way} +
          (SB + AB)'(1);
        if (nxt.st == cache_maint_pkg::ST_WB)
          {nxt.scan_set, nxt.scan_way} = {cur.scan_set, cur.scan_way};
      end
      cache_maint_pkg::ST_WB: begin
        if (mem_done) begin
          nxt.st = cache_maint_pkg::ST_DONE;
          if (cur.is_test)
            {nxt.scan_set, nxt.scan_way} = {cur.scan_set, cur.scan_way} +
              (SB + AB)'(1);
        end
      end
      cache_maint_pkg::ST_FILL: begin
        if (mem_done)
          nxt.st = cache_maint_pkg::ST_DONE;
      end
      cache_maint_pkg::ST_DRAIN: begin
        if (wbuf_empty)
          nxt.st = cur.act == cache_maint_pkg::ACT_INV ?
            cache_maint_pkg::ST_SLEEP : cache_maint_pkg::ST_DONE;
      end
      cache_maint_pkg::ST_SLEEP: begin
        if (cur.irq_sync[1] || cur.dbg_sync[1]) begin
          nxt.st = cache_maint_pkg::ST_DONE;
          nxt.wake = cur.irq_sync[1];
        end
      end
      default: nxt.st = cache_maint_pkg::ST_IDLE;
    endcase
    if (nxt.st == cache_maint_pkg::ST_DONE &&
        cur.st != cache_maint_pkg::ST_DONE &&
        cur.st != cache_maint_pkg::ST_IDLE) begin
      nxt.done = 1'b1;
      if (cur.is_test) begin
        nxt.rvalid = !cur.to_r15;
        nxt.flags = cur.to_r15;
        nxt.rdata = 32'h0000_0000;
        // a line cleaned in this very step still counts as dirty, so
        // the core's loop takes one extra pass before it sees clean
        nxt.rdata[`STATUS_CLEAN_BIT] = !dc_any_dirty;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic on_line;
  assign on_line = cur.st == cache_maint_pkg::ST_LINE;

  assign core_stall = busy || (op_valid &&
    cur.st != cache_maint_pkg::ST_SLEEP);
  assign op_done = cur.done;
  assign read_data = cur.rdata;
  assign read_data_valid = cur.rvalid;
  assign flags_update = cur.flags;
  // Z follows the clean bit so the loop branches on not-equal
  assign flags_nzcv = {1'b0, cur.rdata[`STATUS_CLEAN_BIT], 2'b00};
  assign low_power = cur.st == cache_maint_pkg::ST_SLEEP;
  assign wake_irq = cur.wake;
  assign irq_return_link = cur.link;
  assign dc_set = cur.is_test ? cur.scan_set : op_set;
  assign dc_way = cur.is_test ? cur.scan_way :
    (cur.by_address ? dc_hit_way : op_way);
  assign dc_tag = op_tag;
  assign dc_lookup = (on_line && cur.data_side) ||
    cur.st == cache_maint_pkg::ST_TEST;
  assign ic_lookup = on_line && !cur.data_side;
  assign dc_clear_dirty = cur.st == cache_maint_pkg::ST_WB &&
    mem_done;
  // clean-and-invalidate drops a line with nothing to write back at
  // once; a dirty one goes when its write-back is done
  assign dc_invalidate_line = (on_line && cur.data_side && line_hit &&
    (cur.act == cache_maint_pkg::ACT_INV ||
    (cur.act == cache_maint_pkg::ACT_CLEAN_INV &&
    !(dc_valid && dc_dirty)))) || (dc_clear_dirty &&
    cur.act == cache_maint_pkg::ACT_CLEAN_INV);
  assign ic_invalidate_line = on_line && !cur.data_side &&
    cur.act == cache_maint_pkg::ACT_INV &&
    (cur.by_address ? ic_hit : 1'b1);
  assign dc_invalidate_all = (cur.st == cache_maint_pkg::ST_WHOLE &&
    (cur.data_side || cur.test_inv)) ||
    (nxt.done && cur.is_test && cur.test_inv &&
    nxt.rdata[`STATUS_CLEAN_BIT]);
  assign ic_invalidate_all = cur.st == cache_maint_pkg::ST_WHOLE &&
    (!cur.data_side || cur.test_inv);
  assign line_address = cur.is_test ?
    {{(32 - SB - `SET_LSB){1'b0}}, cur.scan_set, {`SET_LSB{1'b0}}} :
    line_base;
  assign mem_req = cur.st == cache_maint_pkg::ST_WB ||
    cur.st == cache_maint_pkg::ST_FILL;
  assign mem_write = cur.st == cache_maint_pkg::ST_WB;
endmodule // cache_maint

// file: test/cache_maint_checker.sv
// checker for the cache maintenance unit, bound to its top ports
// assumes one clock and requests taken while idle or done
`timescale 1ns/10ps
module cache_maint_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic op_valid,
  input wire logic op_read,
  input wire logic [3:0] secondary_register_field,
  input wire logic [2:0] op_select,
  input wire logic [3:0] dest_reg,
  input wire logic [31:0] instr_address,
  input wire logic wbuf_empty,
  input wire logic core_stall,
  input wire logic op_done,
  input wire logic read_data_valid,
  input wire logic flags_update,
  input wire logic low_power,
  input wire logic wake_irq,
  input wire logic [31:0] irq_return_link,
  input wire logic ic_invalidate_all,
  input wire logic ic_invalidate_line,
  input wire logic mem_req,
  input wire logic mem_write
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic busy, rd, r15;
  logic [3:0] sec;
  logic [2:0] sel;
  logic [31:0] addr;
  logic taken;
  assign taken = op_valid && (!busy || op_done);
  // the request in flight, kept until the next one is taken
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
      {rd, r15, sec, sel, addr} <= '0;
    end else if (taken) begin
      busy <= 1'b1;
      rd <= op_read;
      r15 <= (dest_reg == 4'hF);
      sec <= secondary_register_field;
      sel <= op_select;
      addr <= instr_address;
    end else if (op_done) begin
      busy <= 1'b0;
    end
  end
  stall_take_a: assert property (op_valid |-> core_stall)
    else $error("request not stalled");
  fill_stall_a: assert property (mem_req |-> core_stall)
    else $error("memory work without stall");
  drain_wait_a: assert property (op_done && busy && !rd && sel == 3'h4
    && (sec == 4'hA || sec == 4'h0) |-> $past(wbuf_empty))
    else $error("drain finished with write buffer busy");
  sleep_stall_a: assert property (low_power |-> core_stall)
    else $error("sleeping without stall");
  wake_link_a: assert property (wake_irq |->
    irq_return_link == addr + 32'h0000_0008)
    else $error("return link wrong");
  whole_time_a: assert property (taken && !op_read && op_select == 3'h0
    && secondary_register_field inside {4'h5, 4'h6, 4'h7} |-> ##2 op_done)
    else $error("whole invalidate late");
  ic_all_a: assert property (ic_invalidate_all |-> busy && !rd
    && sel == 3'h0 && (sec == 4'h5 || sec == 4'h7))
    else $error("instruction cache wiped by wrong op");
  ic_line_a: assert property (ic_invalidate_line |-> busy
    && sec == 4'h5 && (sel == 3'h1 || sel == 3'h2))
    else $error("instruction line dropped by wrong op");
  fill_src_a: assert property (mem_req && !mem_write |->
    busy && sec == 4'hD)
    else $error("linefill by wrong op");
  flag_dest_a: assert property (flags_update |-> r15)
    else $error("flags set for plain destination");
  data_dest_a: assert property (read_data_valid |-> !r15)
    else $error("data returned for pc destination");
endmodule // cache_maint_checker

// file: test/cache_side_model.sv
// far side model: data cache dirty state and a slow memory
// assumes 128 sets, every line valid, same-cycle tag answers
`timescale 1ns/10ps
module cache_side_model #(
  parameter int DELAY = 3
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic hit,
  input wire logic [6:0] dc_set,
  input wire logic dc_clear_dirty,
  input wire logic dc_invalidate_line,
  input wire logic dc_invalidate_all,
  input wire logic mem_req,
  output logic dc_hit,
  output logic dc_valid,
  output logic dc_dirty,
  output logic dc_any_dirty,
  output logic ic_hit,
  output logic mem_done
);
  logic [127:0] dirty;
  logic [3:0] cnt;
  assign dc_hit = hit;
  assign ic_hit = hit;
  assign dc_valid = 1'b1;
  assign dc_dirty = dirty[dc_set];
  assign dc_any_dirty = |dirty;
  // ****************************************
  // dirty lines 0, 1, 2 and 100; done comes DELAY cycles into a request
  // ****************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dirty <= (128'h1 << 100) | 128'h7;
      cnt <= 4'h0;
      mem_done <= 1'b0;
    end else begin
      mem_done <= mem_req && !mem_done && cnt == 4'(DELAY - 1);
      cnt <= (mem_req && !mem_done) ? cnt + 4'h1 : 4'h0;
      if (dc_invalidate_all) begin
        dirty <= '0;
      end else if (dc_clear_dirty || dc_invalidate_line) begin
        dirty[dc_set] <= 1'b0;
      end
    end
  end
endmodule // cache_side_model

// file: test/cache_maint_bench.sv
// bench for the cache maintenance unit, one task per scenario
// assumes the side model for tags and memory and the bound checker
`timescale 1ns/10ps
module cache_maint_bench;
  logic clk_sys, reset_n, op_valid, op_read, irq_pin, wbuf_empty;
  logic hit, region_cacheable, zf, dbg_pin;
  logic [3:0] secondary_register_field, dest_reg;
  logic [2:0] op_select;
  logic [31:0] op_data, instr_address, pc;
  logic op_done, read_data_valid, flags_update, low_power, wake_irq;
  logic [3:0] flags_nzcv;
  logic [31:0] read_data, irq_return_link;
  logic [6:0] dc_set;
  logic dc_hit, dc_valid, dc_dirty, dc_any_dirty, ic_hit, mem_done;
  logic dc_clear_dirty, dc_invalidate_line, dc_invalidate_all;
  logic ic_invalidate_line, ic_invalidate_all, mem_req, mem_write;
  logic [9:0] seen;
  int fail_count = 0;
  int n_compared = 0;
  int ncyc;
  cache_maint DUT (.clk_sys(clk_sys), .reset_n(reset_n),
    .op_valid(op_valid), .op_read(op_read), .dest_reg(dest_reg),
    .secondary_register_field(secondary_register_field),
    .op_select(op_select), .op_data(op_data),
    .instr_address(instr_address), .core_stall(), .op_done(op_done),
    .read_data(read_data), .read_data_valid(read_data_valid),
    .flags_update(flags_update), .flags_nzcv(flags_nzcv),
    .irq_pin(irq_pin), .debug_req_pin(dbg_pin), .low_power(low_power),
    .wake_irq(wake_irq), .irq_return_link(irq_return_link),
    .wbuf_empty(wbuf_empty), .dc_set(dc_set), .dc_way(), .dc_tag(),
    .dc_lookup(), .dc_hit(dc_hit), .dc_hit_way(2'h0), .dc_valid(dc_valid),
    .dc_dirty(dc_dirty), .dc_any_dirty(dc_any_dirty),
    .dc_clear_dirty(dc_clear_dirty), .dc_invalidate_line(dc_invalidate_line),
    .dc_invalidate_all(dc_invalidate_all), .ic_lookup(), .ic_hit(ic_hit),
    .ic_hit_way(2'h0), .ic_invalidate_line(ic_invalidate_line),
    .ic_invalidate_all(ic_invalidate_all), .line_address(),
    .region_cacheable(region_cacheable), .mem_req(mem_req),
    .mem_write(mem_write), .mem_done(mem_done));
  cache_side_model side (.clk_sys(clk_sys), .reset_n(reset_n), .hit(hit),
    .dc_set(dc_set), .dc_clear_dirty(dc_clear_dirty),
    .dc_invalidate_line(dc_invalidate_line),
    .dc_invalidate_all(dc_invalidate_all), .mem_req(mem_req),
    .dc_hit(dc_hit), .dc_valid(dc_valid), .dc_dirty(dc_dirty),
    .dc_any_dirty(dc_any_dirty), .ic_hit(ic_hit), .mem_done(mem_done));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // ****************************************
  // sticky record of what each operation touched
  // ****************************************
  always @(negedge clk_sys) begin
    seen |= {wake_irq, low_power, flags_update, read_data_valid,
      mem_req && mem_write, mem_req && !mem_write, dc_invalidate_line,
      ic_invalidate_line, dc_invalidate_all, ic_invalidate_all};
    if (flags_update === 1'b1) zf = flags_nzcv[2];
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic rd, input logic [3:0] sec,
      input logic [2:0] sel, input logic [3:0] dst, input logic [31:0] d);
    @(posedge clk_sys);
    seen = '0;
    op_valid <= 1'b1;
    op_read <= rd;
    secondary_register_field <= sec;
    op_select <= sel;
    dest_reg <= dst;
    op_data <= d;
    instr_address <= pc;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    ncyc = 0;
    while (op_done !== 1'b1 && ncyc < 400) begin
      @(negedge clk_sys);
      ncyc++;
    end
    if (op_done !== 1'b1) chk(op_done, 1'b1);
    @(posedge clk_sys);
  endtask
  // word fields are always zero in the operands below
  task automatic t_clean();
    op(1'b0, 4'hA, 3'h1, 4'h0, 32'h0000_3000);
    chk(seen[5], 1'b1);
    op(1'b0, 4'hA, 3'h2, 4'h0, 32'h0000_0060);
    chk(seen[5], 1'b0);
    op(1'b0, 4'h6, 3'h2, 4'h0, 32'h4000_0020);
    chk(seen[5:3], 3'b001);
    op(1'b0, 4'hE, 3'h1, 4'h0, 32'h0000_5060);
    chk(seen[5:3], 3'b001);
  endtask
  task automatic t_test();
    int wbs;
    wbs = 0;
    for (int i = 0; i < 140; i++) begin
      op(1'b1, 4'hA, 3'h3, 4'h0, 32'h0);
      wbs += seen[5];
      if (i == 0) chk(read_data[30], 1'b0);
      if (read_data[30] === 1'b1) break;
    end
    chk(read_data[30], 1'b1);
    chk(wbs, 2);
    op(1'b1, 4'hA, 3'h3, 4'hF, 32'h0);
    chk(seen[7:6], 2'b10);
    chk(zf, 1'b1);
    op(1'b1, 4'hE, 3'h3, 4'hF, 32'h0);
    chk(seen[1], 1'b1);
  endtask
  task automatic t_prefetch();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      hit <= (i == 1);
      region_cacheable <= (i != 2);
      op(1'b0, 4'hD, 3'h1, 4'h0, 32'h0000_7040);
      chk(seen[4], i == 0);
    end
    hit <= 1'b1;
  endtask
  task automatic t_drain();
    wbuf_empty <= 1'b0;
    fork
      op(1'b0, 4'hA, 3'h4, 4'h0, 32'h0);
      begin
        repeat (10) @(posedge clk_sys);
        wbuf_empty <= 1'b1;
      end
    join
    chk(ncyc >= 9, 1'b1);
  endtask
  task automatic t_wait();
    pc = 32'h0000_1F00;
    wbuf_empty <= 1'b0;
    fork
      op(1'b0, 4'h0, 3'h4, 4'h0, 32'h0);
      begin
        repeat (6) @(posedge clk_sys);
        wbuf_empty <= 1'b1;
        repeat (10) @(posedge clk_sys);
        irq_pin <= 1'b1;
        repeat (12) @(posedge clk_sys);
        irq_pin <= 1'b0;
      end
    join
    chk(ncyc >= 16, 1'b1);
    chk(seen[9:8], 2'b11);
    chk(irq_return_link, 32'h0000_1F08);
    fork
      op(1'b0, 4'h0, 3'h4, 4'h0, 32'h0);
      begin
        repeat (8) @(posedge clk_sys);
        dbg_pin <= 1'b1;
        repeat (6) @(posedge clk_sys);
        dbg_pin <= 1'b0;
      end
    join
    chk(ncyc >= 8, 1'b1);
    chk(seen[9:8], 2'b01);
  endtask
  task automatic t_invalidate();
    op(1'b0, 4'h7, 3'h0, 4'h0, 32'h0);
    chk(seen[1:0], 2'b11);
    op(1'b0, 4'h5, 3'h0, 4'h0, 32'h0);
    chk(seen[1:0], 2'b01);
    op(1'b0, 4'h6, 3'h0, 4'h0, 32'h0);
    chk(seen[1:0], 2'b10);
    op(1'b0, 4'h5, 3'h1, 4'h0, 32'h0000_3020);
    chk(seen[2], 1'b1);
    op(1'b0, 4'h5, 3'h2, 4'h0, 32'hC000_0040);
    chk(seen[2], 1'b1);
  endtask
  task automatic stop_test();
    if (fail_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    {reset_n, op_valid, op_read, irq_pin, dbg_pin} = '0;
    {secondary_register_field, op_select, dest_reg, op_data} = '0;
    {instr_address, pc, seen} = '0;
    {wbuf_empty, hit, region_cacheable} = 3'b111;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_clean();
    t_test();
    t_prefetch();
    t_drain();
    t_wait();
    t_invalidate();
    stop_test();
  end
  initial begin
    #800000;
    fail_count++;
    stop_test();
  end
endmodule // cache_maint_bench
bind cache_maint cache_maint_checker chk_i (.clk_sys(clk_sys),
  .reset_n(reset_n), .op_valid(op_valid), .op_read(op_read),
  .secondary_register_field(secondary_register_field),
  .op_select(op_select), .dest_reg(dest_reg),
  .instr_address(instr_address), .wbuf_empty(wbuf_empty),
  .core_stall(core_stall), .op_done(op_done),
  .read_data_valid(read_data_valid), .flags_update(flags_update),
  .low_power(low_power), .wake_irq(wake_irq),
  .irq_return_link(irq_return_link), .ic_invalidate_all(ic_invalidate_all),
  .ic_invalidate_line(ic_invalidate_line), .mem_req(mem_req),
  .mem_write(mem_write));
